// ---- include/pwm_pkg.sv ----
/*
 Package for the complementary PWM core: register map, field positions,
 reset values and sizes. Assumes a 16-bit carrier counter and 16-bit bus.
*/
package pwm_pkg;
   localparam int CW = 16;
   localparam int AW = 4;
   localparam logic [CW-1:0] ZERO16 = 16'h0000;
   localparam logic [CW-1:0] ONE16  = 16'h0001;
   // Register offsets (word index on the register port)
   localparam logic [AW-1:0] A_MODE    = 4'h0;
   localparam logic [AW-1:0] A_CTRL    = 4'h1;
   localparam logic [AW-1:0] A_STATUS  = 4'h2;
   localparam logic [AW-1:0] A_PERIOD  = 4'h3;
   localparam logic [AW-1:0] A_DEAD    = 4'h4;
   localparam logic [AW-1:0] A_DUTY_U  = 4'h5;
   localparam logic [AW-1:0] A_DUTY_V  = 4'h6;
   localparam logic [AW-1:0] A_DUTY_W  = 4'h7;
   localparam logic [AW-1:0] A_COUNTER = 4'h8;
   // Mode register fields
   localparam int MODE_POS_LVL = 0;
   localparam int MODE_NEG_LVL = 1;
   localparam int MODE_PIN_OUT = 2;
   // Control register fields
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_ADC_EN  = 1;
   localparam int CTRL_CREST_IE  = 2;
   localparam int CTRL_TROUGH_IE = 3;
   localparam int CTRL_ADC_CREST = 4;
   localparam int CTRL_ADC_TROUGH = 5;
   // Status register fields
   localparam int ST_CREST  = 0;
   localparam int ST_TROUGH = 1;
   localparam int ST_UP     = 2;
   localparam int NPH = 3;
endpackage

// ---- include/phase_if.sv ----
/*
 Interface carrying one phase's compare values and outputs between the
 core and a phase waveform module. Assumes a single clock.
*/
`timescale 1ns/1ps
interface phase_if;
   import pwm_pkg::*;
   logic [CW-1:0] upcount_compare;
   logic [CW-1:0] mid_compare;
   logic [CW-1:0] downcount_compare;
   logic          pos_output_gen;
   logic          neg_output_gen;
   modport core (output upcount_compare, output mid_compare,
                 output downcount_compare,
                 input pos_output_gen, input neg_output_gen);
   modport phase (input upcount_compare, input mid_compare,
                  input downcount_compare,
                  output pos_output_gen, output neg_output_gen);
endinterface

// ---- hw/pwm_phase.sv ----
/*
 One phase: compare waveforms, two dead-time counters, output generation.
 Assumes the carrier counter and direction come from the same clock.
*/
`timescale 1ns/1ps
module pwm_phase
   import pwm_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // Carrier state
   input  wire logic          running,
   input  wire logic          count_up,
   input  wire logic [CW-1:0] carrier_counter,
   input  wire logic [CW-1:0] deadtime_value,
   // Compare values and outputs
   phase_if.phase             ph
);
   logic          pos_compare_wave;
   logic          neg_compare_wave;
   logic          pos_cmp_q;
   logic          neg_cmp_q;
   logic [CW-1:0] pos_deadtime_counter;
   logic [CW-1:0] neg_deadtime_counter;
   logic          pos_dt_run;
   logic          neg_dt_run;
   logic          pos_deadtime_wave;
   logic          neg_deadtime_wave;

   always_comb begin
      if (count_up) begin
         pos_compare_wave = !(ph.upcount_compare > carrier_counter);
         neg_compare_wave = ph.mid_compare > carrier_counter;
      end else begin
         pos_compare_wave = !(ph.mid_compare > carrier_counter);
         neg_compare_wave = ph.downcount_compare > carrier_counter;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pos_cmp_q <= 1'b0;
         neg_cmp_q <= 1'b0;
      end else begin
         pos_cmp_q <= pos_compare_wave;
         neg_cmp_q <= neg_compare_wave;
      end
   end

   // Counter runs from the falling edge until it equals the dead time
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pos_dt_run           <= 1'b0;
         pos_deadtime_counter <= ZERO16;
      end else if (pos_dt_run) begin
         if (pos_deadtime_counter + ONE16 == deadtime_value) begin
            pos_dt_run           <= 1'b0;
            pos_deadtime_counter <= ZERO16;
         end else begin
            pos_deadtime_counter <= pos_deadtime_counter + ONE16;
         end
      end else if (running && pos_cmp_q && !pos_compare_wave &&
                   deadtime_value != ZERO16) begin
         // The edge cycle is already the first low cycle of the dead time
         pos_dt_run           <= deadtime_value != ONE16;
         pos_deadtime_counter <= ONE16;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         neg_dt_run           <= 1'b0;
         neg_deadtime_counter <= ZERO16;
      end else if (neg_dt_run) begin
         if (neg_deadtime_counter + ONE16 == deadtime_value) begin
            neg_dt_run           <= 1'b0;
            neg_deadtime_counter <= ZERO16;
         end else begin
            neg_deadtime_counter <= neg_deadtime_counter + ONE16;
         end
      end else if (running && neg_cmp_q && !neg_compare_wave &&
                   deadtime_value != ZERO16) begin
         neg_dt_run           <= deadtime_value != ONE16;
         neg_deadtime_counter <= ONE16;
      end
   end

   // The falling edge itself already counts as the first dead-time cycle
   assign pos_deadtime_wave = !(pos_dt_run ||
      (running && pos_cmp_q && !pos_compare_wave &&
       deadtime_value != ZERO16));
   assign neg_deadtime_wave = !(neg_dt_run ||
      (running && neg_cmp_q && !neg_compare_wave &&
       deadtime_value != ZERO16));

   assign ph.pos_output_gen = pos_compare_wave & neg_deadtime_wave;
   assign ph.neg_output_gen = neg_compare_wave & pos_deadtime_wave;
endmodule

// ---- hw/pwm_core.sv ----
/*
 Three-phase complementary PWM core with dead time, carrier counter,
 external clear, toggle output, A/D and transfer triggers, status flags
 and output protection. Assumes a 40 MHz ref_clk, an external clock-stop
 detector and halt signal, and a simple single-cycle register port.
*/
`timescale 1ns/1ps
// Overview of operation
// - Positive compare wave from up or mid value
// - Negative compare wave from mid or down value
// - Dead-time waves start high after reset
// - Positive dead counter starts at falling edge
// - Negative dead counter starts at falling edge
// - Outputs AND compare with opposite dead wave
// - Pin levels follow active level selects
// - Zero duty buffer gives full positive on
// - Duty above period plus dead gives positive off
// - Clear pin falling edge reloads twice dead
// - Toggle pin high counting up, low down
// - A/D requests at crest or trough, enabled
// - Halt input floats all PWM outputs
// - Clock stop floats all PWM outputs
// - Crest and trough flags request interrupts
// - Matches also trigger data transfer controller
// - Set flag sends conversion start request
// - Counter bounces between twice dead and period plus twice dead
// - Compare values derived from duty buffer
// - Dead counter clears at dead value; zero skips
// - Three phases built identically
module pwm_core
   import pwm_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // Register port
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [CW-1:0] reg_wdata,
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   output logic      [CW-1:0] reg_rdata,
   // PWM pins, order U+ U- V+ V- W+ W-
   output logic      [5:0]    pwm_out,
   output logic      [5:0]    pwm_oe,
   // Clear input or toggle output pin
   input  wire logic          clear_or_toggle_pin_in,
   output logic               clear_or_toggle_pin_out,
   output logic               clear_or_toggle_pin_oe,
   // Protection
   input  wire logic          halt_in,
   input  wire logic          clock_stopped,
   // Event requests
   output logic               crest_interrupt,
   output logic               trough_interrupt,
   output logic               adc_start_request,
   output logic               dtc_crest_request,
   output logic               dtc_trough_request
);
   logic [2:0]    timer_mode_reg;
   logic [5:0]    timer_control_reg;
   logic [1:0]    timer_status_reg;
   logic [CW-1:0] period_buffer;
   logic [CW-1:0] period_compare;
   logic [CW-1:0] deadtime_value;
   logic [CW-1:0] duty_buffer [NPH];
   logic [CW-1:0] carrier_counter;
   logic          count_up;
   logic [CW-1:0] two_dead;
   logic          running;
   logic          crest_match;
   logic          trough_match;
   logic          pin_sync1;
   logic          pin_sync2;
   logic          pin_sync3;
   logic          clear_fall;
   logic          halt_sync1;
   logic          halt_sync2;
   logic          stop_sync1;
   logic          stop_sync2;
   logic          float_out;
   logic [5:0]    gen_bits;
   logic [5:0]    pwm_next;
   logic          sw_clear_crest;
   logic          sw_clear_trough;

   phase_if ph [NPH] ();

   assign two_dead = CW'(deadtime_value << 1);
   assign running  = timer_control_reg[CTRL_RUN];

   // Register writes
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_mode_reg    <= 3'h0;
         timer_control_reg <= 6'h00;
         period_buffer     <= ZERO16;
         deadtime_value    <= ZERO16;
      end else if (reg_write) begin
         unique case (reg_addr)
            A_MODE:   timer_mode_reg    <= reg_wdata[2:0];
            A_CTRL:   timer_control_reg <= reg_wdata[5:0];
            A_PERIOD: period_buffer     <= reg_wdata;
            A_DEAD:   deadtime_value    <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Period compare follows the buffer while stopped and at each trough
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         period_compare <= ZERO16;
      end else if (!running || trough_match) begin
         period_compare <= period_buffer + two_dead;
      end
   end

   generate
      for (genvar i = 0; i < NPH; i++) begin : g_phase
         // Duty buffers transfer immediately on write
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               duty_buffer[i] <= ZERO16;
            end else if (reg_write && reg_addr == A_DUTY_U + AW'(i)) begin
               duty_buffer[i] <= reg_wdata;
            end
         end
         // Zero and above-period duty fall out of the compares
         assign ph[i].downcount_compare = duty_buffer[i];
         assign ph[i].mid_compare = duty_buffer[i] + deadtime_value;
         assign ph[i].upcount_compare = duty_buffer[i] + two_dead;
         pwm_phase u_phase (
            .ref_clk         (ref_clk),
            .rstn            (rstn),
            .running         (running),
            .count_up        (count_up),
            .carrier_counter (carrier_counter),
            .deadtime_value  (deadtime_value),
            .ph              (ph[i])
         );
         assign gen_bits[2*i]   = ph[i].pos_output_gen;
         assign gen_bits[2*i+1] = ph[i].neg_output_gen;
      end
   endgenerate

   // Synchronisers for pin inputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_sync1  <= 1'b1;
         pin_sync2  <= 1'b1;
         pin_sync3  <= 1'b1;
         halt_sync1 <= 1'b0;
         halt_sync2 <= 1'b0;
         stop_sync1 <= 1'b0;
         stop_sync2 <= 1'b0;
      end else begin
         pin_sync1  <= clear_or_toggle_pin_in;
         pin_sync2  <= pin_sync1;
         pin_sync3  <= pin_sync2;
         halt_sync1 <= halt_in;
         halt_sync2 <= halt_sync1;
         stop_sync1 <= clock_stopped;
         stop_sync2 <= stop_sync1;
      end
   end

   assign clear_fall = !timer_mode_reg[MODE_PIN_OUT] &&
                       pin_sync3 && !pin_sync2;

   assign crest_match  = running && count_up &&
                         carrier_counter == period_compare;
   assign trough_match = running && !count_up &&
                         carrier_counter == two_dead;

   // Carrier counter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         carrier_counter <= ZERO16;
         count_up        <= 1'b1;
      end else if (!running || clear_fall) begin
         carrier_counter <= two_dead;
         count_up        <= 1'b1;
      end else if (crest_match) begin
         carrier_counter <= carrier_counter - ONE16;
         count_up        <= 1'b0;
      end else if (trough_match) begin
         carrier_counter <= carrier_counter + ONE16;
         count_up        <= 1'b1;
      end else if (count_up) begin
         carrier_counter <= carrier_counter + ONE16;
      end else begin
         carrier_counter <= carrier_counter - ONE16;
      end
   end

   // Status flags: a write of 0 clears, a new match wins over the clear
   assign sw_clear_crest  = reg_write && reg_addr == A_STATUS &&
                            !reg_wdata[ST_CREST];
   assign sw_clear_trough = reg_write && reg_addr == A_STATUS &&
                            !reg_wdata[ST_TROUGH];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_status_reg <= 2'h0;
      end else begin
         if (crest_match) begin
            timer_status_reg[ST_CREST] <= 1'b1;
         end else if (sw_clear_crest) begin
            timer_status_reg[ST_CREST] <= 1'b0;
         end
         if (trough_match) begin
            timer_status_reg[ST_TROUGH] <= 1'b1;
         end else if (sw_clear_trough) begin
            timer_status_reg[ST_TROUGH] <= 1'b0;
         end
      end
   end

   assign crest_interrupt  = timer_status_reg[ST_CREST] &&
                             timer_control_reg[CTRL_CREST_IE];
   assign trough_interrupt = timer_status_reg[ST_TROUGH] &&
                             timer_control_reg[CTRL_TROUGH_IE];

   // Event pulses, registered one cycle after the match with the flag
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         adc_start_request  <= 1'b0;
         dtc_crest_request  <= 1'b0;
         dtc_trough_request <= 1'b0;
      end else begin
         adc_start_request <= timer_control_reg[CTRL_ADC_EN] &&
            ((crest_match && timer_control_reg[CTRL_ADC_CREST]) ||
             (trough_match && timer_control_reg[CTRL_ADC_TROUGH]));
         dtc_crest_request  <= crest_match;
         dtc_trough_request <= trough_match;
      end
   end

   // Output levels; registered so the pins never glitch on compares
   generate
      for (genvar b = 0; b < 6; b++) begin : g_lvl
         if (b % 2 == 0) begin : g_pos
            assign pwm_next[b] = running &&
               (gen_bits[b] ~^ timer_mode_reg[MODE_POS_LVL]);
         end else begin : g_neg
            assign pwm_next[b] = running &&
               (gen_bits[b] ~^ timer_mode_reg[MODE_NEG_LVL]);
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pwm_out                 <= 6'h00;
         clear_or_toggle_pin_out <= 1'b0;
      end else begin
         pwm_out                 <= pwm_next;
         clear_or_toggle_pin_out <= running && count_up;
      end
   end

   // Protection acts on the synchronised levels; a stopped clock cannot
   // clock anything, so the detector must also gate pads outside
   assign float_out = halt_sync2 || stop_sync2;
   assign pwm_oe    = float_out ? 6'h00 : 6'h3F;
   assign clear_or_toggle_pin_oe = timer_mode_reg[MODE_PIN_OUT] &&
                                   !float_out;

   // Register read, data one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= ZERO16;
      end else if (reg_read) begin
         unique case (reg_addr)
            A_MODE:    reg_rdata <= {13'h0000, timer_mode_reg};
            A_CTRL:    reg_rdata <= {10'h000, timer_control_reg};
            A_STATUS:  reg_rdata <= {13'h0000, count_up, timer_status_reg};
            A_PERIOD:  reg_rdata <= period_buffer;
            A_DEAD:    reg_rdata <= deadtime_value;
            A_DUTY_U:  reg_rdata <= duty_buffer[0];
            A_DUTY_V:  reg_rdata <= duty_buffer[1];
            A_DUTY_W:  reg_rdata <= duty_buffer[2];
            A_COUNTER: reg_rdata <= carrier_counter;
            default:   reg_rdata <= ZERO16;
         endcase
      end else begin
         reg_rdata <= ZERO16;
      end
   end
endmodule

// ---- verif/pwm_core_monitor.sv ----
/*
 Port checker for pwm_core.
 Assumes it is bound to pwm_core and sees only its ports.
*/
`timescale 1ns/1ps
module pwm_core_monitor
   import pwm_pkg::*;
(
   // Clock and reset
   input wire logic          ref_clk,
   input wire logic          rstn,
   // Register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic [CW-1:0] reg_wdata,
   input wire logic          reg_write,
   // Pins
   input wire logic [5:0]    pwm_out,
   input wire logic [5:0]    pwm_oe,
   input wire logic          clear_or_toggle_pin_out,
   input wire logic          clear_or_toggle_pin_oe,
   input wire logic          halt_in,
   input wire logic          clock_stopped,
   // Events
   input wire logic          crest_interrupt,
   input wire logic          trough_interrupt,
   input wire logic          adc_start_request,
   input wire logic          dtc_crest_request,
   input wire logic          dtc_trough_request
);
   logic [CW-1:0] mode_reg;
   logic [CW-1:0] ctrl_reg;
   logic [5:0]    act;
   logic          overlap;
   logic          clr_wr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Shadow copies of the control words, seen on the register port
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= ZERO16;
         ctrl_reg <= ZERO16;
      end else if (reg_write && reg_addr == A_MODE) begin
         mode_reg <= reg_wdata;
      end else if (reg_write && reg_addr == A_CTRL) begin
         ctrl_reg <= reg_wdata;
      end
   end
   always_comb begin
      act = pwm_out ^ {3{~mode_reg[MODE_NEG_LVL], ~mode_reg[MODE_POS_LVL]}};
      overlap = (act[0] & act[1]) | (act[2] & act[3]) | (act[4] & act[5]);
      clr_wr = reg_write && (reg_addr == A_STATUS || reg_addr == A_CTRL);
   end
   AST_NO_OVERLAP: assert property (
      ctrl_reg[CTRL_RUN] [*4] |-> !overlap)
      else $error("both sides of a phase active");
   AST_HALT_FLOAT: assert property (halt_in [*3] |->
      pwm_oe == 6'h00 && !clear_or_toggle_pin_oe)
      else $error("pins driven during halt");
   AST_STOP_FLOAT: assert property (clock_stopped [*3] |->
      pwm_oe == 6'h00 && !clear_or_toggle_pin_oe)
      else $error("pins driven after clock stop");
   AST_TOGGLE_DOWN: assert property (dtc_crest_request &&
      ctrl_reg[CTRL_RUN] |-> ##[0:2] !clear_or_toggle_pin_out)
      else $error("toggle not low after crest");
   AST_TOGGLE_UP: assert property (dtc_trough_request &&
      ctrl_reg[CTRL_RUN] |-> ##[0:2] clear_or_toggle_pin_out)
      else $error("toggle not high after trough");
   AST_CREST_HOLD: assert property (crest_interrupt && !clr_wr |=>
      crest_interrupt)
      else $error("crest request dropped without clear");
   AST_IRQ_MASK: assert property (!(crest_interrupt &&
      !ctrl_reg[CTRL_CREST_IE]) && !(trough_interrupt &&
      !ctrl_reg[CTRL_TROUGH_IE]))
      else $error("interrupt while disabled");
   AST_DTC_FLAG: assert property (dtc_crest_request &&
      ctrl_reg[CTRL_CREST_IE] |-> crest_interrupt)
      else $error("crest transfer request without flag");
   // The pulse follows the match by one cycle, so use the control seen then
   AST_ADC_GATE: assert property (adc_start_request ==
      ($past(ctrl_reg[CTRL_ADC_EN]) &&
      ((dtc_crest_request && $past(ctrl_reg[CTRL_ADC_CREST])) ||
      (dtc_trough_request && $past(ctrl_reg[CTRL_ADC_TROUGH])))))
      else $error("conversion request mismatch");
   COV_CREST: cover property (crest_interrupt);
   COV_ADC: cover property (adc_start_request);
   COV_HALT: cover property (halt_in [*3]);
endmodule

bind pwm_core pwm_core_monitor mon_u (.ref_clk(ref_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .pwm_out(pwm_out), .pwm_oe(pwm_oe),
   .clear_or_toggle_pin_out(clear_or_toggle_pin_out),
   .clear_or_toggle_pin_oe(clear_or_toggle_pin_oe),
   .halt_in(halt_in), .clock_stopped(clock_stopped),
   .crest_interrupt(crest_interrupt), .trough_interrupt(trough_interrupt),
   .adc_start_request(adc_start_request),
   .dtc_crest_request(dtc_crest_request),
   .dtc_trough_request(dtc_trough_request));

// ---- verif/gate_driver_model.sv ----
/*
 Gate drivers and the shared clear/toggle line.
 Assumes floating gate inputs are pulled low and the line pulled high.
*/
`timescale 1ns/1ps
module gate_driver_model (
   // From the PWM core
   input wire logic [5:0] pwm_out,
   input wire logic [5:0] pwm_oe,
   input wire logic       tog_out,
   input wire logic       tog_oe,
   // External open-collector clear source
   input wire logic       clear_pull,
   // Resolved levels
   output logic [5:0]     gate_level,
   output logic           clear_line
);
   // A floating gate sits at its pull-down, so the switch stays off
   assign gate_level = pwm_oe & pwm_out;
   assign clear_line = clear_pull ? 1'h0 : (tog_oe ? tog_out : 1'h1);
endmodule

// ---- verif/complementary_pwm_dead_time_bench.sv ----
/*
 Self-checking bench for pwm_core over its register port.
 Assumes a 40 MHz clock and the gate driver model on the pins.
*/
`timescale 1ns/1ps
module complementary_pwm_dead_time_bench;
   import pwm_pkg::*;
   logic          ref_clk = 1'h0;
   logic          rstn = 1'h0;
   logic [AW-1:0] reg_addr = 4'h0;
   logic [CW-1:0] reg_wdata = 16'h0000;
   logic          reg_write = 1'h0;
   logic          reg_read = 1'h0;
   logic [CW-1:0] reg_rdata, v, pe, ne;
   logic [5:0]    pwm_out, pwm_oe, gate;
   logic          tog_out, tog_oe, line, clr = 1'h0;
   logic          halt_in = 1'h0, clock_stopped = 1'h0;
   logic          c_irq, t_irq, adc_req, c_req, t_req;
   int            n_errors = 0, checks_done = 0;
   int            hi[6], tog_hi, n_cr, n_tr, n_adc, n;
   logic [2:0]    modes[3] = '{3'h7, 3'h0, 3'h7};
   logic [5:0]    ctrls[3] = '{6'h1F, 6'h23, 6'h21};
   // Active cycles per carrier period for duty 0, 8, 30 at period 20, dead 2
   int            pos_on[3] = '{40, 27, 0};
   int            neg_on[3] = '{0, 9, 40};
   always #12.5 ref_clk = ~ref_clk;
   pwm_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .clear_or_toggle_pin_in(line), .clear_or_toggle_pin_out(tog_out),
      .clear_or_toggle_pin_oe(tog_oe), .halt_in(halt_in),
      .clock_stopped(clock_stopped), .crest_interrupt(c_irq),
      .trough_interrupt(t_irq), .adc_start_request(adc_req),
      .dtc_crest_request(c_req), .dtc_trough_request(t_req));
   gate_driver_model drv_u (.pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .tog_out(tog_out), .tog_oe(tog_oe), .clear_pull(clr),
      .gate_level(gate), .clear_line(line));
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge ref_clk);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [CW-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge ref_clk);
      reg_read <= 1'h0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
   // Bounded wait for a crest (0) or trough (1) pulse; n holds the cycles
   task automatic wait_ev(input logic sel);
      for (n = 1; n <= 200; n++) begin
         @(negedge ref_clk);
         if ((sel ? t_req : c_req) === 1'h1) return;
      end
      n_errors++;
      $display("wrong value at %0t: event missing", $time);
      test_done();
   endtask
   task automatic window();
      hi = '{default: 0};
      tog_hi = 0;
      n_cr = 0;
      n_tr = 0;
      n_adc = 0;
      repeat (40) begin
         @(negedge ref_clk);
         for (int k = 0; k < 6; k++) hi[k] += int'(gate[k]);
         tog_hi += int'(tog_out & tog_oe);
         n_cr += int'(c_req);
         n_tr += int'(t_req);
         n_adc += int'(adc_req);
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'h1;
      rd(A_COUNTER, v);
      chk(v, 16'h0000);
      wr(A_DEAD, 16'h0002);
      wr(A_PERIOD, 16'h0014);
      wr(A_DUTY_U, 16'h0000);
      wr(A_DUTY_V, 16'h0008);
      wr(A_DUTY_W, 16'h001E);
      rd(A_COUNTER, v);
      chk(v, 16'h0004);
      rd(4'h9, v);
      chk(v, 16'h0000);
      $display("register test done");
      for (int i = 0; i < 3; i++) begin
         wr(A_CTRL, 16'h0000);
         wr(A_MODE, {13'h0000, modes[i]});
         wr(A_CTRL, {10'h000, ctrls[i]});
         wait_ev(1'h1);
         window();
         for (int p = 0; p < 3; p++) begin
            pe = 16'(modes[i][0] ? pos_on[p] : 40 - pos_on[p]);
            ne = 16'(modes[i][1] ? neg_on[p] : 40 - neg_on[p]);
            chk(16'(hi[2 * p]), pe);
            chk(16'(hi[2 * p + 1]), ne);
         end
         chk(16'(tog_hi), modes[i][2] ? 16'h0014 : 16'h0000);
         chk(16'(n_cr), 16'h0001);
         chk(16'(n_tr), 16'h0001);
         pe = 16'(ctrls[i][1] & (ctrls[i][4] | ctrls[i][5]));
         chk(16'(n_adc), pe);
         chk(16'({c_irq, t_irq}), 16'({ctrls[i][2], ctrls[i][3]}));
         rd(A_STATUS, v);
         chk(16'(v[1:0]), 16'h0003);
         wait_ev(1'h1);
         wr(A_STATUS, 16'h0000);
         @(negedge ref_clk);
         chk(16'({c_irq, t_irq}), 16'h0000);
         wait_ev(1'h0);
         wait_ev(1'h0);
         chk(16'(n), 16'h0028);
         @(posedge ref_clk);
         clr <= 1'h1;
         repeat (4) @(posedge ref_clk);
         clr <= 1'h0;
         wait_ev(1'h0);
         ne = 16'(modes[i][2] ? n == 36 : n >= 19 && n <= 22);
         chk(ne, 16'h0001);
         $display("mode test %0d done", i);
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         halt_in <= (k == 0);
         clock_stopped <= (k == 1);
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(16'({pwm_oe, tog_oe, gate}), 16'h0000);
         @(posedge ref_clk);
         halt_in <= 1'h0;
         clock_stopped <= 1'h0;
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(16'({pwm_oe, tog_oe}), 16'h007F);
      end
      $display("protection test done");
      test_done();
   end
endmodule
